// ===== design/swsiu_defs.vh
// constants for the simd word shuffle and insert unit
`ifndef SWSIU_DEFS_VH
`define SWSIU_DEFS_VH
// operation codes, one-hot not needed: plain 5-bit encoding
`define SWSIU_OP_W 5
`define SWSIU_OP_NOP 5'h00
`define SWSIU_OP_INSERT_WORD 5'h01
`define SWSIU_OP_MASK_NARROW 5'h02
`define SWSIU_OP_MASK_WIDE 5'h03
`define SWSIU_OP_SHUF_NARROW 5'h04
`define SWSIU_OP_SHUF_LOW 5'h05
`define SWSIU_OP_SHUF_HIGH 5'h06
`define SWSIU_OP_SHUF_DWORD 5'h07
`define SWSIU_OP_ILV_LOW 5'h08
`define SWSIU_OP_ILV_HIGH 5'h09
`define SWSIU_OP_NARROW_TO_WIDE 5'h0a
`define SWSIU_OP_WIDE_TO_NARROW 5'h0b
`define SWSIU_OP_CVT_SP_TO_INT 5'h0c
`define SWSIU_OP_CVT_INT_TO_SP 5'h0d
`define SWSIU_OP_CVT_DP_TO_INT 5'h0e
`define SWSIU_OP_CVT_INT_TO_DP 5'h0f
`define SWSIU_OP_XOR 5'h10
`define SWSIU_OP_CMPEQ_B 5'h11
`define SWSIU_OP_CMPEQ_W 5'h12
`define SWSIU_OP_CMPEQ_D 5'h13
`define SWSIU_OP_SUBUS_B 5'h14
`define SWSIU_OP_SUBUS_W 5'h15
`define SWSIU_OP_SLL_W 5'h16
`define SWSIU_OP_SLL_D 5'h17
`define SWSIU_OP_SRL_W 5'h18
`define SWSIU_OP_SRL_D 5'h19
`define SWSIU_OP_SRA_W 5'h1a
`define SWSIU_OP_SRA_D 5'h1b
// insert word slot select position in the control byte
`define SWSIU_INS_SEL_LSB 0
`define SWSIU_INS_SEL_MSB 1
// reset value of the result
`define SWSIU_RESULT_RST 128'h0
`define SWSIU_FLAG_RST 1'b0
`endif

// ===== design/swsiu_word_pick.v
// four-to-one word selector driven by a two-bit index
`default_nettype none
module swsiu_word_pick #(
   parameter WIDTH = 16
) (
   // source words packed low to high
   input wire [4*WIDTH-1:0] src,
   // selected index
   input wire [1:0] sel,
   // picked word
   output wire [WIDTH-1:0] word
);
   assign word = src[sel*WIDTH +: WIDTH];
endmodule // swsiu_word_pick
`default_nettype wire

// ===== design/swsiu_unit.v
// packed integer permute and move datapath, one result per issue
//
// Function
// - insert word from general register or memory
// - control byte bits 1:0 select slot
// - other seven destination words stay unchanged
// - narrow sign mask: 8 bits, upper zero
// - wide sign mask: 16 bits, upper zero
// - narrow shuffle source is register or memory
// - control pairs pick words 0 to 3
// - each pair holds source word index
// - half shuffle, other half passes through
// - dword shuffle routes any field anywhere
// - quadword interleave of low or high halves
// - narrow to wide move clears high half
// - wide to narrow move takes low half
// - four-lane float/int and two-lane double/int conversion
// - xor with itself gives zero
// - equality compare with itself gives ones
// - unsigned saturating subtract clamps, not wraps
// - saturating subtract for bytes and words only
// - shifts only for word and dword lanes
`default_nettype none
`include "swsiu_defs.vh"
module swsiu_unit #(
   parameter WIDE = 128
) (
   // clock, reset, enable
   input wire core_clk,
   input wire reset,
   input wire clk_en,
   // issue
   input wire issue_valid,
   input wire [`SWSIU_OP_W-1:0] op_code,
   input wire [7:0] shuffle_control_byte,
   // operands
   input wire [WIDE-1:0] dest_operand,
   input wire [WIDE-1:0] src_operand,
   input wire [31:0] gp_operand,
   input wire [15:0] mem_word,
   input wire use_mem_word,
   // result
   output reg [WIDE-1:0] result_ff,
   output reg result_valid_ff,
   output reg illegal_op_ff
);
   // ****************************************
   // shuffles
   // ****************************************
   wire [63:0] narrow_src;
   wire [63:0] shuf_lo_src;
   wire [63:0] shuf_hi_src;
   wire [63:0] shuf_narrow;
   wire [63:0] shuf_lo;
   wire [63:0] shuf_hi;
   wire [127:0] shuf_dw;
   assign narrow_src = src_operand[63:0];
   assign shuf_lo_src = src_operand[63:0];
   assign shuf_hi_src = src_operand[127:64];
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_pick
         swsiu_word_pick #(.WIDTH(16)) u_nw (
            .src(narrow_src),
            .sel(shuffle_control_byte[2*gi+1:2*gi]),
            .word(shuf_narrow[16*gi +: 16])
         );
         swsiu_word_pick #(.WIDTH(16)) u_lw (
            .src(shuf_lo_src),
            .sel(shuffle_control_byte[2*gi+1:2*gi]),
            .word(shuf_lo[16*gi +: 16])
         );
         swsiu_word_pick #(.WIDTH(16)) u_hw (
            .src(shuf_hi_src),
            .sel(shuffle_control_byte[2*gi+1:2*gi]),
            .word(shuf_hi[16*gi +: 16])
         );
         swsiu_word_pick #(.WIDTH(32)) u_dw (
            .src(src_operand[127:0]),
            .sel(shuffle_control_byte[2*gi+1:2*gi]),
            .word(shuf_dw[32*gi +: 32])
         );
      end
   endgenerate
   // ****************************************
   // lane helpers
   // ****************************************
   reg [127:0] ins_res;
   reg [15:0] ins_word;
   reg [15:0] sign_mask;
   reg [127:0] lane_res;
   reg [127:0] cvt_res;
   reg [8:0] bdiff;
   reg [16:0] wdiff;
   reg [31:0] dw_in;
   reg [31:0] dw_out;
   reg [63:0] dp_in;
   reg [63:0] dp_out;
   reg [10:0] dp_exp;
   reg [3:0] sh_w;
   reg [4:0] sh_d;
   reg shift_over_w;
   reg shift_over_d;
   integer i;
   integer j;
   always @* begin
      // insertion into the low 64 bits
      ins_word = use_mem_word ? mem_word : gp_operand[15:0];
      ins_res = dest_operand;
      case (shuffle_control_byte[`SWSIU_INS_SEL_MSB:`SWSIU_INS_SEL_LSB])
         2'h0: ins_res[15:0] = ins_word;
         2'h1: ins_res[31:16] = ins_word;
         2'h2: ins_res[47:32] = ins_word;
         default: ins_res[63:48] = ins_word;
      endcase
      for (i = 0; i < 16; i = i + 1) begin
         sign_mask[i] = src_operand[8*i+7];
      end
      sh_w = src_operand[3:0];
      sh_d = src_operand[4:0];
      shift_over_w = (src_operand[63:4] != 60'h0);
      shift_over_d = (src_operand[63:5] != 59'h0);
      lane_res = 128'h0;
      bdiff = 9'h0;
      wdiff = 17'h0;
      case (op_code)
         `SWSIU_OP_XOR: lane_res = dest_operand ^ src_operand;
         `SWSIU_OP_CMPEQ_B: begin
            for (i = 0; i < 16; i = i + 1) begin
               lane_res[8*i +: 8] = (dest_operand[8*i +: 8] == src_operand[8*i +: 8]) ?
                  8'hff : 8'h00;
            end
         end
         `SWSIU_OP_CMPEQ_W: begin
            for (i = 0; i < 8; i = i + 1) begin
               lane_res[16*i +: 16] = (dest_operand[16*i +: 16] ==
                  src_operand[16*i +: 16]) ? 16'hffff : 16'h0000;
            end
         end
         `SWSIU_OP_CMPEQ_D: begin
            for (i = 0; i < 4; i = i + 1) begin
               lane_res[32*i +: 32] = (dest_operand[32*i +: 32] ==
                  src_operand[32*i +: 32]) ? 32'hffffffff : 32'h0;
            end
         end
         `SWSIU_OP_SUBUS_B: begin
            for (i = 0; i < 16; i = i + 1) begin
               bdiff = {1'b0, dest_operand[8*i +: 8]} - {1'b0, src_operand[8*i +: 8]};
               lane_res[8*i +: 8] = bdiff[8] ? 8'h00 : bdiff[7:0];
            end
         end
         `SWSIU_OP_SUBUS_W: begin
            for (i = 0; i < 8; i = i + 1) begin
               wdiff = {1'b0, dest_operand[16*i +: 16]} - {1'b0, src_operand[16*i +: 16]};
               lane_res[16*i +: 16] = wdiff[16] ? 16'h0000 : wdiff[15:0];
            end
         end
         `SWSIU_OP_SLL_W, `SWSIU_OP_SRL_W, `SWSIU_OP_SRA_W: begin
            for (i = 0; i < 8; i = i + 1) begin
               if (op_code == `SWSIU_OP_SLL_W) begin
                  lane_res[16*i +: 16] = shift_over_w ? 16'h0 :
                     dest_operand[16*i +: 16] << sh_w[3:0];
               end else if (op_code == `SWSIU_OP_SRL_W) begin
                  lane_res[16*i +: 16] = shift_over_w ? 16'h0 :
                     dest_operand[16*i +: 16] >> sh_w[3:0];
               end else begin
                  lane_res[16*i +: 16] = $signed(dest_operand[16*i +: 16]) >>>
                     (shift_over_w ? 4'hf : sh_w[3:0]);
               end
            end
         end
         `SWSIU_OP_SLL_D, `SWSIU_OP_SRL_D, `SWSIU_OP_SRA_D: begin
            for (i = 0; i < 4; i = i + 1) begin
               if (op_code == `SWSIU_OP_SLL_D) begin
                  lane_res[32*i +: 32] = shift_over_d ? 32'h0 :
                     dest_operand[32*i +: 32] << sh_d[4:0];
               end else if (op_code == `SWSIU_OP_SRL_D) begin
                  lane_res[32*i +: 32] = shift_over_d ? 32'h0 :
                     dest_operand[32*i +: 32] >> sh_d[4:0];
               end else begin
                  lane_res[32*i +: 32] = $signed(dest_operand[32*i +: 32]) >>>
                     (shift_over_d ? 5'h1f : sh_d[4:0]);
               end
            end
         end
         default: lane_res = 128'h0;
      endcase
   end
   // ****************************************
   // conversions
   // ****************************************
   // integer conversion truncates toward zero; out of range gives 8000_0000
   function [31:0] sp_to_int;
      input [31:0] f;
      reg [7:0] e;
      reg [55:0] m;
      begin
         e = f[30:23];
         m = {32'h0, 1'b1, f[22:0]};
         if (e < 8'd127) begin
            sp_to_int = 32'h0;
         end else if (e > 8'd157) begin
            sp_to_int = 32'h80000000;
         end else begin
            m = (e >= 8'd150) ? (m << (e - 8'd150)) : (m >> (8'd150 - e));
            sp_to_int = f[31] ? (32'h0 - m[31:0]) : m[31:0];
         end
      end
   endfunction
   function [31:0] int_to_sp;
      input [31:0] v;
      reg [31:0] a;
      reg [7:0] e;
      integer k;
      begin
         a = v[31] ? (32'h0 - v) : v;
         e = 8'h0;
         for (k = 0; k < 32; k = k + 1) begin
            if (a[k]) begin
               e = k[7:0];
            end
         end
         if (a == 32'h0) begin
            int_to_sp = 32'h0;
         end else begin
            a = a << (8'd31 - e);
            int_to_sp = {v[31], e + 8'd127, a[30:8]};
         end
      end
   endfunction
   always @* begin
      cvt_res = 128'h0;
      dw_in = 32'h0;
      dw_out = 32'h0;
      dp_in = 64'h0;
      dp_out = 64'h0;
      dp_exp = 11'h0;
      for (j = 0; j < 4; j = j + 1) begin
         dw_in = src_operand[32*j +: 32];
         dw_out = (op_code == `SWSIU_OP_CVT_SP_TO_INT) ? sp_to_int(dw_in) :
            int_to_sp(dw_in);
         cvt_res[32*j +: 32] = dw_out;
      end
      if (op_code == `SWSIU_OP_CVT_DP_TO_INT) begin
         for (j = 0; j < 2; j = j + 1) begin
            dp_in = src_operand[64*j +: 64];
            // rebiased exponent fits eight bits whenever it is used below
            dp_exp = dp_in[62:52] - 11'd896;
            dw_in = {dp_in[63], dp_exp[7:0], dp_in[51:29]};
            if (dp_in[62:52] < 11'd1023) begin
               dw_out = 32'h0;
            end else if (dp_in[62:52] > 11'd1053) begin
               dw_out = 32'h80000000;
            end else begin
               dw_out = sp_to_int(dw_in);
            end
            cvt_res[32*j +: 32] = dw_out;
         end
         cvt_res[127:64] = 64'h0;
      end else if (op_code == `SWSIU_OP_CVT_INT_TO_DP) begin
         for (j = 0; j < 2; j = j + 1) begin
            dw_out = int_to_sp(src_operand[32*j +: 32]);
            dp_out = (dw_out[30:0] == 31'h0) ? {dw_out[31], 63'h0} :
               {dw_out[31], {3'h0, dw_out[30:23]} + 11'd896, dw_out[22:0], 29'h0};
            cvt_res[64*j +: 64] = dp_out;
         end
      end
   end
   // ****************************************
   // result register
   // ****************************************
   reg [127:0] nxt_result;
   reg nxt_illegal;
   always @* begin
      nxt_result = 128'h0;
      nxt_illegal = 1'b0;
      case (op_code)
         `SWSIU_OP_INSERT_WORD: nxt_result = ins_res;
         `SWSIU_OP_MASK_NARROW: nxt_result = {120'h0, sign_mask[7:0]};
         `SWSIU_OP_MASK_WIDE: nxt_result = {112'h0, sign_mask};
         `SWSIU_OP_SHUF_NARROW: nxt_result = {64'h0, shuf_narrow};
         `SWSIU_OP_SHUF_LOW: nxt_result = {src_operand[127:64], shuf_lo};
         `SWSIU_OP_SHUF_HIGH: nxt_result = {shuf_hi, src_operand[63:0]};
         `SWSIU_OP_SHUF_DWORD: nxt_result = shuf_dw;
         `SWSIU_OP_ILV_LOW: nxt_result = {src_operand[63:0], dest_operand[63:0]};
         `SWSIU_OP_ILV_HIGH: nxt_result = {src_operand[127:64], dest_operand[127:64]};
         `SWSIU_OP_NARROW_TO_WIDE: nxt_result = {64'h0, src_operand[63:0]};
         `SWSIU_OP_WIDE_TO_NARROW: nxt_result = {64'h0, src_operand[63:0]};
         `SWSIU_OP_CVT_SP_TO_INT, `SWSIU_OP_CVT_INT_TO_SP, `SWSIU_OP_CVT_DP_TO_INT,
         `SWSIU_OP_CVT_INT_TO_DP: nxt_result = cvt_res;
         `SWSIU_OP_XOR, `SWSIU_OP_CMPEQ_B, `SWSIU_OP_CMPEQ_W, `SWSIU_OP_CMPEQ_D,
         `SWSIU_OP_SUBUS_B, `SWSIU_OP_SUBUS_W, `SWSIU_OP_SLL_W, `SWSIU_OP_SLL_D,
         `SWSIU_OP_SRL_W, `SWSIU_OP_SRL_D, `SWSIU_OP_SRA_W,
         `SWSIU_OP_SRA_D: nxt_result = lane_res;
         // no dword saturating subtract and no byte shift exist: flagged
         default: nxt_illegal = 1'b1;
      endcase
   end
   always @(posedge core_clk) begin
      if (reset) begin
         result_ff <= `SWSIU_RESULT_RST;
         result_valid_ff <= `SWSIU_FLAG_RST;
         illegal_op_ff <= `SWSIU_FLAG_RST;
      end else if (clk_en) begin
         result_valid_ff <= issue_valid & ~nxt_illegal;
         illegal_op_ff <= issue_valid & nxt_illegal;
         if (issue_valid & ~nxt_illegal) begin
            result_ff <= nxt_result;
         end
      end
   end
endmodule // swsiu_unit
`default_nettype wire

// ===== verif/swsiu_core_model.sv
// issue-side model of the core that feeds the unit
`default_nettype none
module swsiu_core_model (
   // clock
   input wire logic core_clk,
   // issue
   output logic issue_valid,
   output logic [4:0] op_code,
   output logic [7:0] shuffle_control_byte,
   output logic [127:0] dest_operand,
   output logic [127:0] src_operand
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      issue_valid = 1'b0;
      op_code = 5'h00;
      shuffle_control_byte = 8'h00;
      dest_operand = 128'h0;
      src_operand = 128'h0;
   end
   // one-cycle issue pulse; released operands turn to their inverse
   task automatic issue(input logic [4:0] op, input logic [7:0] c, input logic [127:0] d, s);
      @(posedge core_clk);
      #1;
      issue_valid = 1'b1;
      op_code = op;
      shuffle_control_byte = c;
      dest_operand = d;
      src_operand = s;
      @(posedge core_clk);
      #1;
      issue_valid = 1'b0;
      dest_operand = ~d;
      src_operand = ~s;
   endtask
endmodule // swsiu_core_model
`default_nettype wire

// ===== verif/swsiu_unit_properties.sv
// assertion checker for the simd word shuffle and insert unit
`default_nettype none
`include "swsiu_defs.vh"
module swsiu_unit_properties #(
   parameter WIDE = 128
) (
   // clock and control
   input wire logic core_clk,
   input wire logic reset,
   input wire logic clk_en,
   // issue and operands
   input wire logic issue_valid,
   input wire logic [`SWSIU_OP_W-1:0] op_code,
   input wire logic [7:0] shuffle_control_byte,
   input wire logic [WIDE-1:0] dest_operand,
   input wire logic [WIDE-1:0] src_operand,
   input wire logic [31:0] gp_operand,
   input wire logic [15:0] mem_word,
   input wire logic use_mem_word,
   // result
   input wire logic [WIDE-1:0] result_ff,
   input wire logic result_valid_ff,
   input wire logic illegal_op_ff
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (reset);
   wire logic take = issue_valid && clk_en;
   wire logic legal = op_code != 5'h00 && op_code <= 5'h1b;
   function automatic logic [WIDE-1:0] msk(input logic [WIDE-1:0] v, input int n);
      msk = '0;
      for (int i = 0; i < n; i++) msk[i] = v[8*i+7];
   endfunction
   function automatic logic [WIDE-1:0] ins(input logic [WIDE-1:0] d, input logic [15:0] w,
      input logic [1:0] k);
      ins = d;
      ins[16*k+:16] = w;
   endfunction
   sequence s_take(logic [4:0] c);
      take && op_code == c;
   endsequence
   AST_LEGAL_DONE: assert property (take && legal |=> result_valid_ff && !illegal_op_ff)
      else $error("legal issue gave no valid pulse");
   AST_REFUSE: assert property (take && !legal |=> illegal_op_ff && $stable(result_ff))
      else $error("illegal issue not refused");
   AST_IDLE: assert property (clk_en && !issue_valid |=> !result_valid_ff && $stable(result_ff))
      else $error("result moved without issue");
   AST_INSERT: assert property (s_take(`SWSIU_OP_INSERT_WORD) |=> result_ff == ins(
      $past(dest_operand), $past(use_mem_word) ? $past(mem_word) : $past(gp_operand[15:0]),
      $past(shuffle_control_byte[1:0]))) else $error("inserted word wrong");
   AST_MASK_NARROW: assert property (s_take(`SWSIU_OP_MASK_NARROW) |=>
      result_ff == msk($past(src_operand), 8)) else $error("narrow byte mask wrong");
   AST_MASK_WIDE: assert property (s_take(`SWSIU_OP_MASK_WIDE) |=>
      result_ff == msk($past(src_operand), 16)) else $error("wide byte mask wrong");
   AST_ILV_LOW: assert property (s_take(`SWSIU_OP_ILV_LOW) |=>
      result_ff == {$past(src_operand[63:0]), $past(dest_operand[63:0])}) else $error("low interleave");
   AST_TO_WIDE: assert property (s_take(`SWSIU_OP_NARROW_TO_WIDE) |=>
      result_ff == {64'h0, $past(src_operand[63:0])}) else $error("narrow to wide move wrong");
   AST_XOR_SELF: assert property (s_take(`SWSIU_OP_XOR) ##0 dest_operand == src_operand |=>
      result_ff == '0) else $error("self xor not zero");
   AST_EQ_SELF: assert property (take && dest_operand == src_operand && op_code >= 5'h11 &&
      op_code <= 5'h13 |=> &result_ff) else $error("self compare not all ones");
endmodule // swsiu_unit_properties
bind swsiu_unit swsiu_unit_properties #(.WIDE(WIDE)) u_props (.core_clk(core_clk), .reset(reset),
   .clk_en(clk_en), .issue_valid(issue_valid), .op_code(op_code),
   .shuffle_control_byte(shuffle_control_byte), .dest_operand(dest_operand),
   .src_operand(src_operand), .gp_operand(gp_operand), .mem_word(mem_word),
   .use_mem_word(use_mem_word), .result_ff(result_ff), .result_valid_ff(result_valid_ff),
   .illegal_op_ff(illegal_op_ff));
`default_nettype wire

// ===== verif/swsiu_unit_bench.sv
// self-checking bench for the simd word shuffle and insert unit
`default_nettype none
`include "swsiu_defs.vh"
module swsiu_unit_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk = 1'b0;
   logic reset = 1'b1;
   logic clk_en = 1'b1;
   logic use_mem_word = 1'b0;
   logic [31:0] gp_operand = 32'habcd_1234;
   logic [15:0] mem_word = 16'h5a5a;
   wire logic issue_valid;
   wire logic [4:0] op_code;
   wire logic [7:0] shuffle_control_byte;
   wire logic [127:0] dest_operand;
   wire logic [127:0] src_operand;
   wire logic [127:0] result_ff;
   wire logic result_valid_ff;
   wire logic illegal_op_ff;
   logic [127:0] a = 128'hfedc_ba98_7654_3210_0f1e_2d3c_4b5a_6978;
   logic [127:0] b = 128'h0123_4567_89ab_cdef_f0e1_d2c3_b4a5_9687;
   logic [127:0] e;
   logic [127:0] f;
   int mismatches = 0;
   int check_count = 0;
   initial begin
      forever #20 core_clk = ~core_clk;
   end
   swsiu_core_model core (.core_clk(core_clk), .issue_valid(issue_valid), .op_code(op_code),
      .shuffle_control_byte(shuffle_control_byte), .dest_operand(dest_operand),
      .src_operand(src_operand));
   swsiu_unit uut (.core_clk(core_clk), .reset(reset), .clk_en(clk_en),
      .issue_valid(issue_valid), .op_code(op_code), .shuffle_control_byte(shuffle_control_byte),
      .dest_operand(dest_operand), .src_operand(src_operand), .gp_operand(gp_operand),
      .mem_word(mem_word), .use_mem_word(use_mem_word), .result_ff(result_ff),
      .result_valid_ff(result_valid_ff), .illegal_op_ff(illegal_op_ff));
   function automatic logic [63:0] sw(input logic [63:0] v, input logic [7:0] c);
      for (int i = 0; i < 4; i++) sw[16*i+:16] = v[16*c[2*i+:2]+:16];
   endfunction
   function automatic logic [127:0] sd(input logic [127:0] v, input logic [7:0] c);
      for (int i = 0; i < 4; i++) sd[32*i+:32] = v[32*c[2*i+:2]+:32];
   endfunction
   task automatic chk(input logic [127:0] x, input logic v, input logic bad);
      check_count++;
      if (result_ff !== x || result_valid_ff !== v || illegal_op_ff !== bad) begin
         mismatches++;
         $display("wrong value at %0t: got %h want %h", $time, result_ff, x);
      end
   endtask
   task automatic run(input logic [4:0] op, input logic [7:0] c, input logic [127:0] d, s, x);
      core.issue(op, c, d, s);
      chk(x, 1'b1, 1'b0);
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic t_insert();
      for (int k = 0; k < 4; k++) begin
         e = a;
         e[16*k+:16] = 16'h1234;
         run(`SWSIU_OP_INSERT_WORD, 8'hfc | 8'(k), a, b, e);
      end
      use_mem_word = 1'b1;
      e = a;
      e[31:16] = 16'h5a5a;
      run(`SWSIU_OP_INSERT_WORD, 8'h01, a, b, e);
      use_mem_word = 1'b0;
      e = 128'hffff_0000_0000_0000_8000_ff01_7f80_0081;
      run(`SWSIU_OP_MASK_NARROW, 8'h00, b, e, 128'ha5);
      run(`SWSIU_OP_MASK_WIDE, 8'h00, b, e, 128'hc0a5);
      $display("test insert and mask done");
   endtask
   task automatic t_shuffle();
      for (int i = 0; i < 2; i++) begin
         logic [7:0] c;
         c = i ? 8'h9c : 8'h1b;
         run(`SWSIU_OP_SHUF_NARROW, c, b, a, {64'h0, sw(a[63:0], c)});
         run(`SWSIU_OP_SHUF_LOW, c, b, a, {a[127:64], sw(a[63:0], c)});
         run(`SWSIU_OP_SHUF_HIGH, c, b, a, {sw(a[127:64], c), a[63:0]});
         run(`SWSIU_OP_SHUF_DWORD, c, b, a, sd(a, c));
      end
      run(`SWSIU_OP_SHUF_NARROW, 8'h1b, b, a, 128'h6978_4b5a_2d3c_0f1e);
      run(`SWSIU_OP_ILV_LOW, 8'h00, a, b, {b[63:0], a[63:0]});
      run(`SWSIU_OP_ILV_HIGH, 8'h00, a, b, {b[127:64], a[127:64]});
      run(`SWSIU_OP_NARROW_TO_WIDE, 8'h00, b, a, {64'h0, a[63:0]});
      run(`SWSIU_OP_WIDE_TO_NARROW, 8'h00, b, a, {64'h0, a[63:0]});
      $display("test shuffle and move done");
   endtask
   task automatic t_arith();
      e = 128'h0000_0000_bf80_0000_4000_0000_3f80_0000;
      f = 128'h0000_0000_ffff_ffff_0000_0002_0000_0001;
      run(`SWSIU_OP_CVT_INT_TO_SP, 8'h00, a, f, e);
      run(`SWSIU_OP_CVT_SP_TO_INT, 8'h00, a, e, f);
      e = 128'hc000_0000_0000_0000_3ff0_0000_0000_0000;
      run(`SWSIU_OP_CVT_DP_TO_INT, 8'h00, a, e, 128'hffff_fffe_0000_0001);
      run(`SWSIU_OP_CVT_INT_TO_DP, 8'h00, a, 128'hffff_fffe_0000_0001, e);
      run(`SWSIU_OP_XOR, 8'h00, a, a, 128'h0);
      for (int i = 0; i < 3; i++) run(5'h11 + 5'(i), 8'h00, a, a, '1);
      run(`SWSIU_OP_SUBUS_B, 8'h00, 128'h10ff_8000, 128'h2001_7f00, 128'h00fe_0100);
      run(`SWSIU_OP_SUBUS_W, 8'h00, 128'h0001_ffff, 128'h0002_0001, 128'hfffe);
      e = 128'hffff_ffff_0000_0000_0000_0000_0000_0000;
      f = 128'hedc0_a980_6540_2100_f1e0_d3c0_b5a0_9780;
      run(`SWSIU_OP_SLL_W, 8'h00, a, 128'h4, f);
      f = 128'h0fed_cba9_0765_4321_00f1_e2d3_04b5_a697;
      run(`SWSIU_OP_SRL_D, 8'h00, a, 128'h4, f);
      run(`SWSIU_OP_SRA_W, 8'h00, a, 128'hf, e);
      run(`SWSIU_OP_SRA_D, 8'h00, a, 128'h28, e);
      run(`SWSIU_OP_SRL_W, 8'h00, a, 128'h10, 128'h0);
      run(`SWSIU_OP_SLL_D, 8'h00, a, 128'h28, 128'h0);
      $display("test arithmetic done");
   endtask
   task automatic t_refuse();
      e = {64'h0, a[63:0]};
      run(`SWSIU_OP_NARROW_TO_WIDE, 8'h00, b, a, e);
      for (int i = 27; i < 32; i++) begin
         core.issue(i == 27 ? 5'h00 : 5'(i), 8'h00, a, b);
         chk(e, 1'b0, 1'b1);
      end
      // enable low holds every output, the refusal flag as well
      clk_en = 1'b0;
      core.issue(`SWSIU_OP_XOR, 8'h00, a, a);
      chk(e, 1'b0, 1'b1);
      clk_en = 1'b1;
      reset = 1'b1;
      @(posedge core_clk);
      #1;
      reset = 1'b0;
      chk(128'h0, 1'b0, 1'b0);
      $display("test refuse and reset done");
   endtask
   initial begin
      repeat (6) @(posedge core_clk);
      #1;
      reset = 1'b0;
      chk(128'h0, 1'b0, 1'b0);
      t_insert();
      t_shuffle();
      t_arith();
      t_refuse();
      print_verdict();
   end
   initial begin
      #20000;
      mismatches++;
      print_verdict();
   end
endmodule // swsiu_unit_bench
`default_nettype wire
